// ---- pbcr_pkg.sv ----
// Constants for the PHY basic control register bank
package pbcr_pkg;
  localparam int          PBCR_NUM_REGS    = 32;
  localparam logic [4:0]  PBCR_ADDR_CTRL   = 5'h00;
  localparam logic [4:0]  PBCR_ADDR_STAT   = 5'h01;
  localparam logic [4:0]  PBCR_ADDR_XOVER  = 5'h1C;
  localparam logic [4:0]  PBCR_VENDOR_BASE = 5'h10;
  // Control field positions
  localparam int          PBCR_B_RESET     = 15;
  localparam int          PBCR_B_LOOP      = 14;
  localparam int          PBCR_B_SPD_LSB   = 13;
  localparam int          PBCR_B_ANEN      = 12;
  localparam int          PBCR_B_PDOWN     = 11;
  localparam int          PBCR_B_ISO       = 10;
  localparam int          PBCR_B_ANRST     = 9;
  localparam int          PBCR_B_DUPLEX    = 8;
  localparam int          PBCR_B_COLTEST   = 7;
  localparam int          PBCR_B_SPD_MSB   = 6;
  // Writable control bits; bits 5:0 read zero
  localparam logic [15:0] PBCR_CTRL_WMASK  = 16'hFF_C0;
  localparam logic [15:0] PBCR_CTRL_RESET  = 16'h11_00;
  localparam logic [15:0] PBCR_XOVER_RESET = 16'h00_00;
  // Status word fixed part, link bit at 2
  localparam logic [15:0] PBCR_STAT_FIXED  = 16'h79_49;
  localparam int          PBCR_B_LINK      = 2;
  // Speed codes as {bit 6, bit 13}
  localparam logic [1:0]  PBCR_SPD_10      = 2'h0;
  localparam logic [1:0]  PBCR_SPD_100     = 2'h1;
  localparam logic [1:0]  PBCR_SPD_1000    = 2'h2;
  localparam logic [1:0]  PBCR_SPD_RSVD    = 2'h3;
  // Global reset pulse length in cycles
  localparam int          PBCR_GRST_CYC    = 4;
endpackage

// ---- pbcr_regs.sv ----
// PHY basic control register bank with mode decode
// Behaviour
// [RULE1] Registers are a 32-entry directly addressed space, 0h-Fh standard and 10h-1Fh vendor.
// [RULE2] Writing one to control bit 15 starts a soft reset and the bit clears itself.
// [RULE3] Writing one to control bit 9 restarts negotiation and the bit clears itself.
// [RULE4] Forced speed {bit6,bit13} decodes 10=1000, 01=100, 00=10 and 11 reserved.
// [RULE5] With negotiation enabled the forced speed bits are ignored for the negotiated speed.
// [RULE6] Negotiation enable defaults to one and its outcome overrides speed and duplex bits.
// [RULE7] Clearing negotiation enable turns off automatic crossover, which then comes from register 1Ch.
// [RULE8] Control bit 11 powers the PHY down and the link status may not update meanwhile.
// [RULE9] The manager treats the link as down while powered down.
// [RULE10] A one-to-zero change of power-down issues an internal global reset.
// [RULE11] The manager waits at least 1 ms after leaving power-down before accessing registers.
// [RULE12] Control bit 10 isolates the PHY from the MAC data interface, default zero.
// [RULE13] Control bit 14 enables loopback, default zero.
// [RULE14] Control bits 5:0 read zero, duplex defaults to full, collision test to off.
`timescale 1ns/1ps
module pbcr_regs
  import pbcr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        spd_strap_in,
  input  wire logic        link_up_in,
  input  wire logic [1:0]  an_speed_in,
  input  wire logic        an_duplex_in,
  output logic             soft_reset_out,
  output logic             an_restart_out,
  output logic             global_reset_out,
  output logic [1:0]       speed_out,
  output logic             duplex_out,
  output logic             speed_rsvd_out,
  output logic             auto_xover_en_out,
  output logic [15:0]      xover_cfg_out,
  output logic             power_down_out,
  output logic             isolate_out,
  output logic             loopback_out,
  output logic             col_test_out
);

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] xover_r;
  logic        strap_done_r;
  logic        pdown_q_r;
  logic        link_r;
  logic [2:0]  grst_cnt_r;
  logic [15:0] rdata_nxt;
  logic        soft_rst_r;
  logic        an_rst_r;
  // Strap synchroniser stages and filtered level
  logic        strap_s1_r;
  logic        strap_s2_r;
  logic        strap_s3_r;
  logic        strap_sync_r;

  // Register number match, shared by the write and read paths
  function automatic logic addr_is(input logic [4:0] a, input logic [4:0] n);
    return (a == n);
  endfunction

  // Address decode over the 5-bit space
  wire         hit_ctrl   = addr_is(reg_addr_in, PBCR_ADDR_CTRL);            // [RULE1]
  wire         hit_stat   = addr_is(reg_addr_in, PBCR_ADDR_STAT);
  wire         hit_xover  = addr_is(reg_addr_in, PBCR_ADDR_XOVER);           // [RULE1]
  wire         wr_ctrl    = ce_in && reg_wr_in && hit_ctrl;
  wire         wr_xover   = ce_in && reg_wr_in && hit_xover;
  wire         pdown_fall = pdown_q_r && !ctrl_r[PBCR_B_PDOWN];              // [RULE10]
  wire         grst_on    = (grst_cnt_r != 3'd0);
  wire         any_reset  = rst_in || soft_rst_r || grst_on;
  wire         ctrl_clear = rst_in || (ce_in && any_reset);                  // [RULE2] [RULE10]

  // Next control value: writable bits only, self-clearing bits drop after one cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt[PBCR_B_RESET] = 1'b0;                                           // [RULE2]
    ctrl_nxt[PBCR_B_ANRST] = 1'b0;                                           // [RULE3]
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata_in & PBCR_CTRL_WMASK;                             // [RULE14]
    end
    if (!strap_done_r) begin
      ctrl_nxt[PBCR_B_SPD_MSB] = strap_sync_r;                               // Speed MSB default from strap
    end
  end

  // Control register; soft and global resets return it to defaults
  always_ff @(posedge clk_in) begin
    if (ctrl_clear) begin
      ctrl_r <= PBCR_CTRL_RESET;                                             // [RULE6] [RULE14]
    end else if (ce_in) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Strap is taken once, on the first enabled cycle after any reset
  always_ff @(posedge clk_in) begin
    if (ctrl_clear) begin
      strap_done_r <= 1'b0;
    end else if (ce_in) begin
      strap_done_r <= 1'b1;
    end
  end

  // Strap pin synchroniser; no reset so the level is ready when reset ends
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      strap_s1_r <= spd_strap_in;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
    end
  end

  // Filtered strap level, moves only when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (ce_in && (strap_s2_r == strap_s3_r)) begin
      strap_sync_r <= strap_s3_r;
    end
  end

  // Crossover register, kept across soft and global resets
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xover_r <= PBCR_XOVER_RESET;
    end else if (wr_xover) begin
      xover_r <= reg_wdata_in;                                               // [RULE7]
    end
  end

  // Self-clearing command bits become one-cycle strobes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      soft_rst_r <= 1'b0;
      an_rst_r   <= 1'b0;
    end else if (ce_in) begin
      soft_rst_r <= ctrl_r[PBCR_B_RESET];                                    // [RULE2]
      an_rst_r   <= ctrl_r[PBCR_B_ANRST];                                    // [RULE3]
    end
  end

  // Power-down history for exit detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pdown_q_r <= 1'b0;
    end else if (ce_in) begin
      pdown_q_r <= ctrl_r[PBCR_B_PDOWN];                                     // [RULE10]
    end
  end

  // Global reset counter, loaded on power-down exit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      grst_cnt_r <= 3'd0;
    end else if (ce_in) begin
      if (pdown_fall) begin
        grst_cnt_r <= 3'(PBCR_GRST_CYC);                                     // [RULE10]
      end else if (grst_on) begin
        grst_cnt_r <= grst_cnt_r - 3'd1;
      end
    end
  end

  // Link status held while powered down, sampled otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      link_r <= 1'b0;
    end else if (ce_in && !ctrl_r[PBCR_B_PDOWN]) begin
      link_r <= link_up_in;                                                  // [RULE8]
    end
  end

  // Read data mux; vendor registers other than 1Ch and unmapped registers read zero
  always_comb begin
    rdata_nxt = 16'h00_00;
    if (hit_ctrl) begin
      rdata_nxt = ctrl_r & PBCR_CTRL_WMASK;                                  // [RULE14]
    end else if (hit_stat) begin
      rdata_nxt = PBCR_STAT_FIXED;
      rdata_nxt[PBCR_B_LINK] = link_r;
    end else if (hit_xover) begin
      rdata_nxt = xover_r;
    end
  end

  // Registered read data, held until the next read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h00_00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Mode decode toward the PHY core
  wire [1:0] forced_spd = {ctrl_r[PBCR_B_SPD_MSB], ctrl_r[PBCR_B_SPD_LSB]};  // [RULE4]
  wire       an_on      = ctrl_r[PBCR_B_ANEN];

  assign speed_out         = an_on ? an_speed_in : forced_spd;               // [RULE5] [RULE6]
  assign duplex_out        = an_on ? an_duplex_in : ctrl_r[PBCR_B_DUPLEX];   // [RULE6]
  assign speed_rsvd_out    = !an_on && (forced_spd == PBCR_SPD_RSVD);        // [RULE4]
  assign auto_xover_en_out = an_on;                                          // [RULE7]
  assign xover_cfg_out     = xover_r;

  // Power and data path controls
  assign power_down_out    = ctrl_r[PBCR_B_PDOWN];                           // [RULE8]
  assign isolate_out       = ctrl_r[PBCR_B_ISO];                             // [RULE12]
  assign loopback_out      = ctrl_r[PBCR_B_LOOP];                            // [RULE13]
  assign col_test_out      = ctrl_r[PBCR_B_COLTEST];

  // Reset and restart strobes toward the core
  assign soft_reset_out    = soft_rst_r;
  assign an_restart_out    = an_rst_r;
  assign global_reset_out  = grst_on && !rst_in;                             // [RULE10]

endmodule

// ---- pbcr_regs_props.sv ----
// Concurrent checks on the basic control register bank ports
`timescale 1ns/1ps
module pbcr_regs_props
  import pbcr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [1:0] an_speed_in,
  input wire logic       an_duplex_in,
  input wire logic       soft_reset_out,
  input wire logic       an_restart_out,
  input wire logic       global_reset_out,
  input wire logic [1:0] speed_out,
  input wire logic       duplex_out,
  input wire logic       speed_rsvd_out,
  input wire logic       auto_xover_en_out,
  input wire logic       power_down_out,
  input wire logic       loopback_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Self-clearing pulses, soft reset restores defaults
  a_soft_pulse: assert property (soft_reset_out |=> !soft_reset_out && auto_xover_en_out && !loopback_out)
    else $error("soft reset pulse wrong");
  a_restart_pulse: assert property (an_restart_out |=> !an_restart_out)
    else $error("restart pulse too long");
  // Negotiated result wins while negotiation is on
  a_an_override: assert property (auto_xover_en_out |-> speed_out == an_speed_in && duplex_out == an_duplex_in)
    else $error("negotiated mode not used");
  a_rsvd_flag: assert property (speed_rsvd_out |-> !auto_xover_en_out && speed_out == PBCR_SPD_RSVD)
    else $error("reserved flag without code");
  a_rsvd_seen: assert property (!auto_xover_en_out && speed_out == PBCR_SPD_RSVD |-> speed_rsvd_out)
    else $error("reserved code not flagged");
  // Power-down exit gives a fixed global reset
  a_grst_len: assert property ($fell(power_down_out) |=> global_reset_out [*4] ##1 !global_reset_out)
    else $error("global reset length wrong");
  a_grst_ctrl: assert property (global_reset_out |=> !power_down_out && auto_xover_en_out)
    else $error("global reset left control set");
  a_reset_vals: assert property ($fell(rst_in) |-> auto_xover_en_out && !loopback_out && !power_down_out)
    else $error("reset values wrong");
endmodule
bind pbcr_regs pbcr_regs_props i_props (.clk_in, .rst_in, .an_speed_in, .an_duplex_in, .soft_reset_out,
  .an_restart_out, .global_reset_out, .speed_out, .duplex_out, .speed_rsvd_out, .auto_xover_en_out,
  .power_down_out, .loopback_out);

// ---- pbcr_mgmt_model.sv ----
// Station management controller model driving the register strobes
`timescale 1ns/1ps
module pbcr_mgmt_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic      [4:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out
);
  initial {addr_out, wr_out, rd_out, wdata_out} = '0;
  // One access a call, strobe held across a single edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_in) #1;
    {addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
    @(posedge clk_in) #1;
    {wr_out, rd_out} = 2'h0;
    q = rdata_in;
  endtask
  // Stay off the bus 1 ms after leaving power-down, link taken as down
  task automatic pd_wait();
    repeat (25000) @(posedge clk_in);
  endtask
endmodule

// ---- tb_phy_basic_control_regs.sv ----
// Testbench for the basic control register bank
`timescale 1ns/1ps
module tb_phy_basic_control_regs;
  import pbcr_pkg::*;
  logic        clk_in = 0, rst_in = 1, link = 1, wr, rd, dup, rsv, ax, pd, iso, lb;
  logic [1:0]  spd;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, q;
  int          fails = 0, n_checks = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  pbcr_mgmt_model i_mgr (.clk_in, .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  pbcr_regs i_dut (.clk_in, .rst_in, .ce_in(1'b1), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .spd_strap_in(1'b0), .link_up_in(link),
    .an_speed_in(PBCR_SPD_1000), .an_duplex_in(1'b1), .soft_reset_out(), .an_restart_out(),
    .global_reset_out(), .speed_out(spd), .duplex_out(dup), .speed_rsvd_out(rsv), .auto_xover_en_out(ax),
    .xover_cfg_out(), .power_down_out(pd), .isolate_out(iso), .loopback_out(lb), .col_test_out());
  task automatic chk(input string s, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wrr(input logic [4:0] a, input logic [15:0] d);
    i_mgr.acc(1'b1, a, d, q);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic rdc(input string s, input logic [4:0] a, input logic [15:0] e);
    i_mgr.acc(1'b0, a, 16'h0000, q);
    chk(s, e, q);
  endtask
  task automatic t_defaults();
    rdc("ctrl", 5'h00, 16'h1100);
    rdc("stat", 5'h01, 16'h794D);
    rdc("vendor", 5'h1F, 16'h0000);
  endtask
  task automatic t_speed();
    logic [1:0]  k;
    logic [15:0] d;
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      d = 16'h003F | (16'(k[1]) << 6) | (16'(k[0]) << 13);
      wrr(5'h00, d);
      chk("mode", {12'h000, rsv, ax, spd}, {12'h000, k == 2'h3, 1'b0, k});
      rdc("ctrl", 5'h00, d & 16'hFFC0);
    end
    wrr(5'h00, 16'h3000);
    chk("an", {13'h0000, dup, spd}, {13'h0001, PBCR_SPD_1000});
  endtask
  task automatic t_self();
    wrr(5'h1C, 16'hA5A5);
    wrr(5'h00, 16'h1300);
    rdc("ctrl", 5'h00, 16'h1100);
    wrr(5'h00, 16'h8000);
    rdc("ctrl", 5'h00, 16'h1100);
    rdc("xover", 5'h1C, 16'hA5A5);
  endtask
  task automatic t_pd();
    wrr(5'h00, 16'h4C00);
    chk("pd", {13'h0000, pd, iso, lb}, 16'h0007);
    @(posedge clk_in) #1 link = 0;
    repeat (2) @(posedge clk_in);
    rdc("stat_pd", 5'h01, 16'h794D);
    wrr(5'h00, 16'h1500);
    i_mgr.pd_wait();
    chk("pd", {13'h0000, pd, iso, lb}, 16'h0000);
    rdc("stat_up", 5'h01, 16'h7949);
    rdc("ctrl", 5'h00, 16'h1100);
  endtask
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    #1 rst_in = 0;
    t_defaults();
    t_speed();
    t_self();
    t_pd();
    finish_test();
  end
endmodule
